// *** rtl/slot_alloc_pkg.sv ***
// constants and types for the slot i/o number allocator
// assumes one 10 MHz clock; all settings are static while an allocation runs
//
// Behaviour
// R01: allocation runs after every power-on and every controller reset.
// R02: slots numbered from main base slot 0, every base counted as eight slots.
// R03: global empty-slot points 0 to 64 in steps of 16, default 16.
// R04: per-slot settings optional; type is empty, input, output or special.
// R05: per-slot point count 0 to 64 in 16-point steps, no default.
// R06: per-slot first i/o number 0 to 1FFF on 16-point boundaries.
// R07: stores module, supply and cable names, up to 16 characters each.
// R08: unset type or point count taken from the loaded module.
// R09: unset first number follows accumulated points of preceding slots.
// R10: overlapping allocated ranges raise the slot layout error.
// R11: assigned parameters apply whatever module is loaded.
// R12: fewer assigned points than loaded makes upper module points unusable.
// R13: more assigned points than loaded reserves surplus as dummy points.
// R14: loaded i/o module in a slot assigned empty becomes unusable.
// R15: unassigned slots continue numbering after assigned ones.
// R16: input as output gives no input, and vice versa; special mismatch errors.
// R17: configuring party matches special modules; two-slot ones as empty 16 plus special 32.
// R18: configuring party assigns hybrid i/o modules as output.
// R19: supply name takes no part in allocation, only in diagnostics.
// R20: configuring party assigns master and remote stations; local only its own.
// R21: result held until next power-on or reset; layout error is a status flag.
package slot_alloc_pkg;
  localparam int NUM_BASES = 8;
  localparam int SLOTS_PER_BASE = 8;
  localparam int NSLOT = NUM_BASES * SLOTS_PER_BASE;
  localparam int SLOT_W = 6;
  localparam int BASE_W = 3;
  localparam int UNIT_W = 3;
  localparam int FIRST_W = 9;
  localparam int SUM_W = 10;
  localparam int PTS_W = 7;
  localparam int IO_W = 13;
  localparam int NAME_LEN = 16;
  localparam int CHAR_IDX_W = 4;
  localparam int CHAR_W = 8;
  localparam logic [UNIT_W-1:0] MAX_UNITS = 3'h4;
  localparam logic [UNIT_W-1:0] DEFAULT_EMPTY_UNITS = 3'h1;
  localparam logic [SLOT_W-1:0] LAST_SLOT = 6'h3F;
  localparam logic [SUM_W-1:0] FIRST_LIMIT = 10'h200;

  typedef enum logic [1:0] {
    TYPE_EMPTY,
    TYPE_INPUT,
    TYPE_OUTPUT,
    TYPE_SPECIAL
  } slot_type_t;

  typedef enum logic [1:0] {
    NAME_MODULE,
    NAME_SUPPLY,
    NAME_CABLE
  } name_kind_t;
endpackage

// *** rtl/slot_io_number_allocator.sv ***
// slot i/o number allocator: resolves per-slot settings into i/o ranges
// assumes settings and detected modules are stable from reset release to done
`timescale 1ns/1ps
module slot_io_number_allocator (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // global empty-slot points, in units of 16
  input wire logic empty_units_set,
  input wire logic [slot_alloc_pkg::UNIT_W-1:0] empty_units,
  // per-slot settings
  input wire logic cfg_type_set [slot_alloc_pkg::NSLOT],
  input wire slot_alloc_pkg::slot_type_t cfg_type [slot_alloc_pkg::NSLOT],
  input wire logic cfg_units_set [slot_alloc_pkg::NSLOT],
  input wire logic [slot_alloc_pkg::UNIT_W-1:0] cfg_units [slot_alloc_pkg::NSLOT],
  input wire logic cfg_first_set [slot_alloc_pkg::NSLOT],
  input wire logic [slot_alloc_pkg::FIRST_W-1:0] cfg_first [slot_alloc_pkg::NSLOT],
  // detected modules
  input wire slot_alloc_pkg::slot_type_t det_type [slot_alloc_pkg::NSLOT],
  input wire logic [slot_alloc_pkg::UNIT_W-1:0] det_units [slot_alloc_pkg::NSLOT],
  // name store
  input wire logic name_wr,
  input wire slot_alloc_pkg::name_kind_t name_kind,
  input wire logic [slot_alloc_pkg::SLOT_W-1:0] name_sel,
  input wire logic [slot_alloc_pkg::CHAR_IDX_W-1:0] name_char,
  input wire logic [slot_alloc_pkg::CHAR_W-1:0] name_wdata,
  output logic [slot_alloc_pkg::CHAR_W-1:0] name_rdata,
  // status
  output logic busy,
  output logic done,
  output logic slot_layout_error,
  output logic controller_error,
  output logic setting_error,
  // resolved allocation per slot
  output slot_alloc_pkg::slot_type_t alloc_type [slot_alloc_pkg::NSLOT],
  output logic [slot_alloc_pkg::IO_W-1:0] alloc_first [slot_alloc_pkg::NSLOT],
  output logic [slot_alloc_pkg::PTS_W-1:0] alloc_points [slot_alloc_pkg::NSLOT],
  output logic [slot_alloc_pkg::PTS_W-1:0] usable_points [slot_alloc_pkg::NSLOT],
  output logic [slot_alloc_pkg::PTS_W-1:0] dummy_points [slot_alloc_pkg::NSLOT],
  output logic input_enable [slot_alloc_pkg::NSLOT],
  output logic output_enable [slot_alloc_pkg::NSLOT],
  output logic special_enable [slot_alloc_pkg::NSLOT]
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [1:0] {
    ST_SCAN,
    ST_CHECK,
    ST_DONE
  } state_t;
  localparam int NW = slot_alloc_pkg::NSLOT;
  localparam int UW = slot_alloc_pkg::UNIT_W;
  localparam int FW = slot_alloc_pkg::FIRST_W;
  localparam int SW = slot_alloc_pkg::SUM_W;
  state_t state_r, state_nxt;
  logic [slot_alloc_pkg::SLOT_W-1:0] idx_r, idx_nxt;
  logic [slot_alloc_pkg::SLOT_W-1:0] jdx_r, jdx_nxt;
  logic [SW-1:0] next_r, next_nxt;
  logic lay_err_r, lay_err_nxt;
  logic ctl_err_r, ctl_err_nxt;
  logic set_err_r, set_err_nxt;
  logic [FW-1:0] first_r [NW];
  logic [UW-1:0] units_r [NW];
  logic [UW-1:0] use_r [NW];
  logic [UW-1:0] dum_r [NW];
  slot_alloc_pkg::slot_type_t type_r [NW];
  logic in_en_r [NW];
  logic out_en_r [NW];
  logic sp_en_r [NW];
  // per-slot resolution of the slot under scan
  slot_alloc_pkg::slot_type_t res_type;
  slot_alloc_pkg::slot_type_t det;
  logic [UW-1:0] res_units;
  logic [UW-1:0] res_use;
  logic [UW-1:0] res_dum;
  logic [UW-1:0] glob_units;
  logic [FW-1:0] res_first;
  logic res_bad;
  logic res_cerr;
  logic scan_we;
  // overlap test between slots idx_r and jdx_r
  logic [SW-1:0] end_i, end_j;
  logic overlap;

  ////////////////////////////////////////////////////////////////////////////
  // slot resolution
  always_comb begin
    det = det_type[idx_r];
    res_bad = 1'b0;
    // global empty-slot points, default when unset or out of range
    if (empty_units_set && empty_units <= slot_alloc_pkg::MAX_UNITS) begin // [R03]
      glob_units = empty_units;
    end else begin
      glob_units = slot_alloc_pkg::DEFAULT_EMPTY_UNITS; // [R03]
      res_bad = empty_units_set;
    end
    // assigned type wins, else the loaded module's
    res_type = cfg_type_set[idx_r] ? cfg_type[idx_r] : det; // [R04] [R08] [R11]
    if (cfg_units_set[idx_r]) begin // [R05] [R11]
      if (cfg_units[idx_r] > slot_alloc_pkg::MAX_UNITS) begin
        res_units = slot_alloc_pkg::MAX_UNITS;
        res_bad = 1'b1;
      end else begin
        res_units = cfg_units[idx_r];
      end
    end else if (det == slot_alloc_pkg::TYPE_EMPTY) begin
      res_units = glob_units; // [R03]
    end else begin
      res_units = det_units[idx_r]; // [R08]
    end
    // explicit first number, else continue from accumulated points
    if (cfg_first_set[idx_r]) begin // [R06] [R11]
      res_first = cfg_first[idx_r];
    end else begin
      res_first = next_r[FW-1:0]; // [R09] [R15]
      if (next_r >= slot_alloc_pkg::FIRST_LIMIT) begin
        res_bad = 1'b1;
      end
    end
    // usable part is truncated, surplus is dummy
    if (res_type == slot_alloc_pkg::TYPE_EMPTY || det == slot_alloc_pkg::TYPE_EMPTY) begin
      res_use = '0; // [R14]
    end else if (det_units[idx_r] < res_units) begin
      res_use = det_units[idx_r];
    end else begin
      res_use = res_units; // [R12]
    end
    if (res_type == slot_alloc_pkg::TYPE_EMPTY) begin
      res_dum = '0;
    end else begin
      res_dum = res_units - res_use; // [R13]
    end
    // i/o against special in either direction is a controller error
    res_cerr = ((det == slot_alloc_pkg::TYPE_INPUT || det == slot_alloc_pkg::TYPE_OUTPUT)
                && res_type == slot_alloc_pkg::TYPE_SPECIAL)
               || (det == slot_alloc_pkg::TYPE_SPECIAL
                && (res_type == slot_alloc_pkg::TYPE_INPUT
                    || res_type == slot_alloc_pkg::TYPE_OUTPUT)); // [R16]
  end
  ////////////////////////////////////////////////////////////////////////////
  // overlap test
  always_comb begin
    end_i = SW'(first_r[idx_r]) + SW'(units_r[idx_r]);
    end_j = SW'(first_r[jdx_r]) + SW'(units_r[jdx_r]);
    overlap = (units_r[idx_r] != '0) && (units_r[jdx_r] != '0)
              && (SW'(first_r[idx_r]) < end_j)
              && (SW'(first_r[jdx_r]) < end_i); // [R10]
  end
  ////////////////////////////////////////////////////////////////////////////
  // sequencer: scan every slot in order, then compare every pair
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    jdx_nxt = jdx_r;
    next_nxt = next_r;
    lay_err_nxt = lay_err_r;
    ctl_err_nxt = ctl_err_r;
    set_err_nxt = set_err_r;
    scan_we = 1'b0;
    unique case (state_r)
      ST_SCAN: begin
        // absent slots read as empty, so every base spans eight slots
        scan_we = 1'b1; // [R02]
        next_nxt = SW'(res_first) + SW'(res_units); // [R09] [R15]
        ctl_err_nxt = ctl_err_r | res_cerr; // [R16]
        set_err_nxt = set_err_r | res_bad;
        if (idx_r == slot_alloc_pkg::LAST_SLOT) begin
          state_nxt = ST_CHECK;
          idx_nxt = '0;
          jdx_nxt = 6'h01;
        end else begin
          idx_nxt = idx_r + 6'h01; // [R02]
        end
      end
      ST_CHECK: begin
        lay_err_nxt = lay_err_r | overlap; // [R10]
        if (jdx_r == slot_alloc_pkg::LAST_SLOT) begin
          if (idx_r == slot_alloc_pkg::LAST_SLOT - 6'h01) begin
            state_nxt = ST_DONE;
          end else begin
            idx_nxt = idx_r + 6'h01;
            jdx_nxt = idx_r + 6'h02;
          end
        end else begin
          jdx_nxt = jdx_r + 6'h01;
        end
      end
      ST_DONE: begin
        state_nxt = ST_DONE; // [R21]
      end
    endcase
  end
  // reset restarts the whole allocation
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_SCAN; // [R01]
      idx_r <= '0; // [R02]
      jdx_r <= '0;
      next_r <= '0;
      lay_err_r <= 1'b0;
      ctl_err_r <= 1'b0;
      set_err_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      jdx_r <= jdx_nxt;
      next_r <= next_nxt;
      lay_err_r <= lay_err_nxt;
      ctl_err_r <= ctl_err_nxt;
      set_err_r <= set_err_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // result table, written once per slot and then held
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int k = 0; k < NW; k++) begin
        first_r[k] <= '0;
        units_r[k] <= '0;
        use_r[k] <= '0;
        dum_r[k] <= '0;
        type_r[k] <= slot_alloc_pkg::TYPE_EMPTY;
        in_en_r[k] <= 1'b0;
        out_en_r[k] <= 1'b0;
        sp_en_r[k] <= 1'b0;
      end
    end else if (scan_we) begin // [R21]
      first_r[idx_r] <= res_first;
      units_r[idx_r] <= res_units;
      use_r[idx_r] <= res_use;
      dum_r[idx_r] <= res_dum;
      type_r[idx_r] <= res_type;
      // a module acts only where loaded and assigned types agree
      in_en_r[idx_r] <= det == slot_alloc_pkg::TYPE_INPUT
                        && res_type == slot_alloc_pkg::TYPE_INPUT; // [R16] [R14]
      out_en_r[idx_r] <= det == slot_alloc_pkg::TYPE_OUTPUT
                         && res_type == slot_alloc_pkg::TYPE_OUTPUT; // [R16] [R18]
      sp_en_r[idx_r] <= det == slot_alloc_pkg::TYPE_SPECIAL
                        && res_type == slot_alloc_pkg::TYPE_SPECIAL; // [R17]
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // name store; supply names never feed the allocation
  logic [slot_alloc_pkg::CHAR_W-1:0] mod_name [NW*slot_alloc_pkg::NAME_LEN];
  logic [slot_alloc_pkg::CHAR_W-1:0] sup_name [slot_alloc_pkg::NUM_BASES*slot_alloc_pkg::NAME_LEN];
  logic [slot_alloc_pkg::CHAR_W-1:0] cab_name [slot_alloc_pkg::NUM_BASES*slot_alloc_pkg::NAME_LEN];
  logic [slot_alloc_pkg::SLOT_W+slot_alloc_pkg::CHAR_IDX_W-1:0] slot_addr;
  logic [slot_alloc_pkg::BASE_W+slot_alloc_pkg::CHAR_IDX_W-1:0] base_addr;
  logic [slot_alloc_pkg::CHAR_W-1:0] name_rdata_nxt;
  always_comb begin
    slot_addr = {name_sel, name_char};
    base_addr = {name_sel[slot_alloc_pkg::BASE_W-1:0], name_char};
    unique case (name_kind)
      slot_alloc_pkg::NAME_SUPPLY: name_rdata_nxt = sup_name[base_addr]; // [R19]
      slot_alloc_pkg::NAME_CABLE: name_rdata_nxt = cab_name[base_addr];
      default: name_rdata_nxt = mod_name[slot_addr];
    endcase
  end
  always_ff @(posedge clk) begin
    if (name_wr) begin // [R07]
      unique case (name_kind)
        slot_alloc_pkg::NAME_SUPPLY: sup_name[base_addr] <= name_wdata;
        slot_alloc_pkg::NAME_CABLE: cab_name[base_addr] <= name_wdata;
        default: mod_name[slot_addr] <= name_wdata;
      endcase
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      name_rdata <= '0;
    end else begin
      name_rdata <= name_rdata_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign busy = state_r != ST_DONE;
  assign done = state_r == ST_DONE;
  assign slot_layout_error = lay_err_r; // [R21]
  assign controller_error = ctl_err_r;
  assign setting_error = set_err_r;
  always_comb begin
    for (int k = 0; k < NW; k++) begin
      alloc_type[k] = type_r[k];
      alloc_first[k] = {first_r[k], 4'h0};
      alloc_points[k] = {units_r[k], 4'h0};
      usable_points[k] = {use_r[k], 4'h0};
      dummy_points[k] = {dum_r[k], 4'h0};
      input_enable[k] = in_en_r[k];
      output_enable[k] = out_en_r[k];
      special_enable[k] = sp_en_r[k];
    end
  end
endmodule

// *** dv/slot_alloc_props.sv ***
// checker for the slot allocator status and result ports
// assumes it is bound to the allocator top, one clock domain
`timescale 1ns/1ps
module slot_alloc_props (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // status
  input wire logic busy,
  input wire logic done,
  input wire logic slot_layout_error,
  input wire logic controller_error,
  // results
  input wire slot_alloc_pkg::slot_type_t alloc_type [slot_alloc_pkg::NSLOT],
  input wire logic [slot_alloc_pkg::IO_W-1:0] alloc_first [slot_alloc_pkg::NSLOT],
  input wire logic [slot_alloc_pkg::PTS_W-1:0] alloc_points [slot_alloc_pkg::NSLOT],
  input wire logic [slot_alloc_pkg::PTS_W-1:0] usable_points [slot_alloc_pkg::NSLOT],
  input wire logic [slot_alloc_pkg::PTS_W-1:0] dummy_points [slot_alloc_pkg::NSLOT],
  input wire logic input_enable [slot_alloc_pkg::NSLOT],
  input wire logic output_enable [slot_alloc_pkg::NSLOT],
  // settings
  input wire logic cfg_first_set [slot_alloc_pkg::NSLOT]
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // edges since reset release, held at 2080
  logic [11:0] cnt_r;
  logic [11:0] cnt_nxt;
  always_comb begin
    cnt_nxt = (cnt_r == 12'h820) ? cnt_r : cnt_r + 12'h001;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 12'h000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  ////////////////////////////////////////
  // end of the previous slot's range, where an unset first number must start
  logic [slot_alloc_pkg::IO_W-1:0] chain [slot_alloc_pkg::NSLOT];
  always_comb begin
    chain[0] = '0;
    for (int k = 1; k < slot_alloc_pkg::NSLOT; k++) begin
      chain[k] = alloc_first[k-1] + slot_alloc_pkg::IO_W'(alloc_points[k-1]);
    end
  end
  ////////////////////////////////////////
  property p_busy_run; cnt_r < 12'h820 |-> busy && !done; endproperty
  a_busy_run: assert property (p_busy_run) else $error("busy dropped early");
  property p_done_at; cnt_r == 12'h820 |-> done && !busy; endproperty
  a_done_at: assert property (p_done_at) else $error("done late");
  property p_done_hold; done |=> done; endproperty
  a_done_hold: assert property (p_done_hold) else $error("done fell");
  property p_lay_hold; !busy |=> $stable(slot_layout_error) && $stable(controller_error); endproperty
  a_lay_hold: assert property (p_lay_hold) else $error("flag moved after done");
  for (genvar i = 0; i < slot_alloc_pkg::NSLOT; i++) begin : g_slot
    property p_res_hold; done |=> $stable(alloc_first[i]) && $stable(alloc_points[i]); endproperty
    a_res_hold: assert property (p_res_hold) else $error("result moved");
    property p_in_en; input_enable[i] |-> alloc_type[i] == slot_alloc_pkg::TYPE_INPUT; endproperty
    a_in_en: assert property (p_in_en) else $error("input enable on non-input");
    property p_out_en; output_enable[i] |-> alloc_type[i] == slot_alloc_pkg::TYPE_OUTPUT; endproperty
    a_out_en: assert property (p_out_en) else $error("output enable on non-output");
    property p_usable; usable_points[i] <= alloc_points[i]; endproperty
    a_usable: assert property (p_usable) else $error("usable above assigned");
    property p_empty;
      alloc_type[i] == slot_alloc_pkg::TYPE_EMPTY |-> usable_points[i] == 7'h00 && !input_enable[i];
    endproperty
    a_empty: assert property (p_empty) else $error("empty slot usable");
    property p_chain; done && !cfg_first_set[i] |-> alloc_first[i] == chain[i]; endproperty
    a_chain: assert property (p_chain) else $error("unset first not consecutive");
    property p_dummy;
      dummy_points[i] == ((alloc_type[i] == slot_alloc_pkg::TYPE_EMPTY) ? 7'h00
                          : alloc_points[i] - usable_points[i]);
    endproperty
    a_dummy: assert property (p_dummy) else $error("dummy points wrong");
  end
  c_done: cover property ($rose(done));
  c_lay: cover property ($rose(slot_layout_error));
  c_ctl: cover property ($rose(controller_error));
endmodule

// *** dv/slot_module_model.sv ***
// model of the modules seated in the base slots
// assumes the bench loads modules before it resets the allocator
`timescale 1ns/1ps
module slot_module_model (
  // detected modules
  output slot_alloc_pkg::slot_type_t det_type [slot_alloc_pkg::NSLOT],
  output logic [slot_alloc_pkg::UNIT_W-1:0] det_units [slot_alloc_pkg::NSLOT]
);
  // absent slots read as empty with no points
  task automatic clear();
    foreach (det_type[k]) begin
      det_type[k] = slot_alloc_pkg::TYPE_EMPTY;
      det_units[k] = 3'h0;
    end
  endtask
  // seat a module of type t with u units of 16 points in slot s
  task automatic load(input int s, input slot_alloc_pkg::slot_type_t t, input logic [2:0] u);
    det_type[s] = t;
    det_units[s] = u;
  endtask
  initial clear();
endmodule

// *** dv/slot_io_number_allocator_test.sv ***
// self-checking bench for the slot i/o number allocator
// assumes the slot module model and the props checker are compiled first
`timescale 1ns/1ps
module slot_io_number_allocator_test;
  localparam slot_alloc_pkg::slot_type_t t_emp = slot_alloc_pkg::TYPE_EMPTY;
  localparam slot_alloc_pkg::slot_type_t t_in = slot_alloc_pkg::TYPE_INPUT;
  localparam slot_alloc_pkg::slot_type_t t_out = slot_alloc_pkg::TYPE_OUTPUT;
  localparam slot_alloc_pkg::slot_type_t t_spc = slot_alloc_pkg::TYPE_SPECIAL;
  logic clk, sys_rst, empty_units_set, name_wr, busy, done;
  logic slot_layout_error, controller_error, setting_error;
  logic [2:0] empty_units;
  logic cfg_type_set [64], cfg_units_set [64], cfg_first_set [64];
  logic input_enable [64], output_enable [64], special_enable [64];
  slot_alloc_pkg::slot_type_t cfg_type [64], det_type [64], alloc_type [64];
  logic [2:0] cfg_units [64], det_units [64];
  logic [8:0] cfg_first [64];
  logic [12:0] alloc_first [64];
  logic [6:0] alloc_points [64], usable_points [64], dummy_points [64];
  slot_alloc_pkg::name_kind_t name_kind;
  logic [5:0] name_sel;
  logic [3:0] name_char;
  logic [7:0] name_wdata, name_rdata;
  int err_count, checks_done;
  slot_io_number_allocator uut (.clk, .sys_rst, .empty_units_set, .empty_units,
    .cfg_type_set, .cfg_type, .cfg_units_set, .cfg_units, .cfg_first_set, .cfg_first,
    .det_type, .det_units, .name_wr, .name_kind, .name_sel, .name_char, .name_wdata,
    .name_rdata, .busy, .done, .slot_layout_error, .controller_error, .setting_error,
    .alloc_type, .alloc_first, .alloc_points, .usable_points, .dummy_points,
    .input_enable, .output_enable, .special_enable);
  slot_module_model model (.det_type, .det_units);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic clear();
    empty_units_set = 1'b0;
    empty_units = 3'h0;
    foreach (cfg_type[k]) begin
      cfg_type_set[k] = 1'b0;
      cfg_type[k] = t_emp;
      cfg_units_set[k] = 1'b0;
      cfg_units[k] = 3'h0;
      cfg_first_set[k] = 1'b0;
      cfg_first[k] = 9'h000;
    end
    model.clear();
  endtask
  task automatic asg(input int s, input slot_alloc_pkg::slot_type_t t, input logic [2:0] u);
    // only this station's own slots are ever assigned
    cfg_type_set[s] = 1'b1;
    cfg_type[s] = t;
    cfg_units_set[s] = 1'b1;
    cfg_units[s] = u;
  endtask
  task automatic run();
    sys_rst = 1'b1;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    for (int n = 0; n < 2200 && done !== 1'b1; n++) @(negedge clk);
    chk("done", done, 16'h1);
  endtask
  ////////////////////////////////////////
  task automatic t_empty();
    logic [15:0] e;
    for (int i = 0; i < 4; i++) begin
      clear();
      model.load(0, t_in, 3'h2);
      model.load(1, t_out, 3'h1);
      empty_units_set = (i < 3);
      empty_units = (i == 0) ? 3'h0 : (i == 1) ? 3'h4 : 3'h5;
      e = (i == 0) ? 16'h0 : (i == 1) ? 16'h40 : 16'h10;
      run();
      chk("pts0", alloc_points[0], 16'h20);
      chk("first2", alloc_first[2], 16'h30);
      chk("first8", alloc_first[8], 16'h30 + e * 16'h6);
      chk("first63", alloc_first[63], 16'h30 + e * 16'd61);
      chk("set_err", setting_error, 16'(i == 2));
      chk("in_en0", input_enable[0], 16'h1);
      chk("layout", slot_layout_error, 16'h0);
    end
  endtask
  task automatic t_assign();
    clear();
    model.load(0, t_in, 3'h2);
    asg(0, t_in, 3'h1);
    model.load(1, t_in, 3'h1);
    asg(1, t_in, 3'h2);
    model.load(2, t_out, 3'h1);
    asg(2, t_emp, 3'h1);
    model.load(3, t_in, 3'h1);
    asg(3, t_out, 3'h1);
    model.load(4, t_out, 3'h1);
    run();
    chk("usable0", usable_points[0], 16'h10);
    chk("dummy1", dummy_points[1], 16'h10);
    chk("out_en2", output_enable[2], 16'h0);
    chk("type3", alloc_type[3], t_out);
    chk("in_en3", input_enable[3], 16'h0);
    chk("first4", alloc_first[4], 16'h50);
    chk("out_en4", output_enable[4], 16'h1);
  endtask
  task automatic t_first_and_special();
    for (int i = 0; i < 2; i++) begin
      clear();
      model.load(0, t_in, 3'h2);
      cfg_first_set[1] = 1'b1;
      cfg_first[1] = (i == 0) ? 9'h020 : 9'h001;
      model.load(1, t_spc, 3'h2);
      asg(1, t_spc, 3'h2); // special set as the module needs
      model.load(3, (i == 0) ? t_spc : t_in, 3'h1);
      asg(3, (i == 0) ? t_in : t_spc, 3'h1);
      run();
      chk("first1", alloc_first[1], (i == 0) ? 16'h200 : 16'h10);
      chk("first2", alloc_first[2], (i == 0) ? 16'h220 : 16'h30);
      chk("layout", slot_layout_error, 16'(i));
      chk("spc_en1", special_enable[1], 16'h1);
      chk("ctl_err", controller_error, 16'h1);
    end
  endtask
  task automatic t_names();
    for (int k = 0; k < 6; k++) begin
      name_kind = slot_alloc_pkg::name_kind_t'(k % 3);
      name_sel = 6'h05;
      for (int c = 0; c < 16; c++) begin
        name_wr = (k < 3);
        name_char = 4'(c);
        name_wdata = 8'(k % 3 * 16 + c + 1);
        @(negedge clk);
        if (k > 2) chk("name", name_rdata, 16'(k % 3 * 16 + c + 1));
      end
    end
    name_wr = 1'b0;
  endtask
  ////////////////////////////////////////
  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (25000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    {sys_rst, name_wr, name_sel, name_char, name_wdata} = '0;
    name_kind = slot_alloc_pkg::NAME_MODULE;
    err_count = 0;
    checks_done = 0;
    clear();
    t_empty();
    t_names();
    t_assign();
    t_first_and_special();
    report_and_stop();
  end
endmodule
bind slot_io_number_allocator slot_alloc_props chk_i (.clk, .sys_rst, .busy, .done,
  .slot_layout_error, .controller_error, .alloc_type, .alloc_first, .alloc_points,
  .usable_points, .dummy_points, .input_enable, .output_enable, .cfg_first_set);
